/* src/sxdap_defs.vh */
// Constants for the stretched external data access unit with dual data pointers.
// Assumes a core special-function-register bus with 8-bit addresses and data.
`ifndef SXDAP_DEFS_VH
`define SXDAP_DEFS_VH
`define SXDAP_CLKS_PER_MC      3'h4
`define SXDAP_ADDR_PTR0_LOW    8'h82
`define SXDAP_ADDR_PTR0_HIGH   8'h83
`define SXDAP_ADDR_PTR1_LOW    8'h84
`define SXDAP_ADDR_PTR1_HIGH   8'h85
`define SXDAP_ADDR_PTR_SEL     8'h86
`define SXDAP_ADDR_CLOCK_AND_STRETCH_CONTROL       8'h8E
`define SXDAP_STRETCH_LSB      0
`define SXDAP_STRETCH_MSB      2
`define SXDAP_SEL_BIT          0
`define SXDAP_STRETCH_RESET    3'h1
`define SXDAP_CLOCK_AND_STRETCH_CONTROL_RESET      8'h01
`define SXDAP_PTR_RESET        16'h0000
`define SXDAP_SEL_RESET        1'h0
`define SXDAP_MIN_MC           4'h2
`define SXDAP_ADDR_CLKS        5'h02
`define SXDAP_STROBE_ZERO      5'h02
`endif

/* src/sxdap_ptr_bank.v */
// Two 16-bit data pointers with a select bit, written over the register bus.
// Assumes the core never loads and increments the pointer in the same cycle.
`timescale 1ns/1ns
`default_nettype none
`include "sxdap_defs.vh"
module sxdap_ptr_bank (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Register writes
    input  wire        wr_i,
    input  wire [7:0]  addr_i,
    input  wire [7:0]  wdata_i,
    // Core pointer operations
    input  wire        inc_ptr_i,
    input  wire        inc_sel_i,
    input  wire        load_ptr_i,
    input  wire [15:0] load_val_i,
    // State
    output reg  [15:0] ptr0_o,
    output reg  [15:0] ptr1_o,
    output reg         sel_o
);
    wire [15:0] act_ptr = sel_o ? ptr1_o : ptr0_o;
    wire [15:0] act_inc = act_ptr + 16'h0001;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ptr0_o <= `SXDAP_PTR_RESET;
            ptr1_o <= `SXDAP_PTR_RESET;
            sel_o  <= `SXDAP_SEL_RESET; // see RQ14
        end else begin
            if (wr_i && addr_i == `SXDAP_ADDR_PTR0_LOW) ptr0_o[7:0] <= wdata_i; // see RQ9
            if (wr_i && addr_i == `SXDAP_ADDR_PTR0_HIGH) ptr0_o[15:8] <= wdata_i; // see RQ9
            if (wr_i && addr_i == `SXDAP_ADDR_PTR1_LOW) ptr1_o[7:0] <= wdata_i; // see RQ10
            if (wr_i && addr_i == `SXDAP_ADDR_PTR1_HIGH) ptr1_o[15:8] <= wdata_i; // see RQ10
            if (wr_i && addr_i == `SXDAP_ADDR_PTR_SEL) sel_o <= wdata_i[`SXDAP_SEL_BIT]; // see RQ11
            else if (inc_sel_i) sel_o <= ~sel_o; // see RQ13
            // Only the selected pointer moves; the full carry ripples into the high byte.
            if (load_ptr_i || inc_ptr_i) begin // see RQ12
                if (sel_o) ptr1_o <= load_ptr_i ? load_val_i : act_inc; // see RQ16
                else ptr0_o <= load_ptr_i ? load_val_i : act_inc; // see RQ16
            end
        end
    end
endmodule // sxdap_ptr_bank
`default_nettype wire

/* src/sxdap_top.v */
// Stretched external data move engine with dual data pointers.
// Assumes the core issues one move request at a time and waits for done.
`timescale 1ns/1ns
`default_nettype none
`include "sxdap_defs.vh"
// Function
// RQ1 - A machine cycle is exactly four clocks and all access lengths count in them.
// RQ2 - The stretch setting lives in the low three bits of the clock control register at 8Eh.
// RQ3 - An external data move lasts the stretch setting plus two machine cycles.
// RQ4 - Reset loads a stretch of one, giving three-cycle moves.
// RQ5 - The strobe is two clocks at stretch zero and otherwise four clocks per stretch step.
// RQ6 - The stretch applies only to external data moves, never to code fetches.
// RQ7 - The stretch may be rewritten at any time and applies to later moves.
// RQ8 - Addresses go out on the muxed address/data port with the high byte on its own port.
// RQ9 - The first data pointer sits at 82h low and 83h high.
// RQ10 - The second data pointer sits at 84h low and 85h high.
// RQ11 - Bit 0 of register 86h selects the pointer and the other bits read zero.
// RQ12 - Every pointer operation uses the currently selected pointer.
// RQ13 - Incrementing the select register toggles the active pointer.
// RQ14 - Reset selects the first data pointer.
// RQ15 - The external memory answers within the strobe width set by the stretch.
// RQ16 - A pointer increment carries fully from low byte to high byte of the active pointer.
module sxdap_top (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Special function register bus
    input  wire        sfr_wr_i,
    input  wire        sfr_rd_i,
    input  wire [7:0]  sfr_addr_i,
    input  wire [7:0]  sfr_wdata_i,
    output reg  [7:0]  sfr_rdata_o,
    // Core pointer operations
    input  wire        inc_ptr_i,
    input  wire        inc_sel_i,
    input  wire        load_ptr_i,
    input  wire [15:0] load_val_i,
    // External data move request
    input  wire        xmove_req_i,
    input  wire        xmove_write_i,
    input  wire        xmove_use_ptr_i,
    input  wire [7:0]  xmove_ri_addr_i,
    input  wire [7:0]  xmove_wdata_i,
    output reg         xmove_busy_o,
    output reg         xmove_done_o,
    output reg  [7:0]  xmove_rdata_o,
    // External memory pins
    input  wire [7:0]  muxed_addr_data_port_i,
    output reg  [7:0]  muxed_addr_data_port_o,
    output reg         muxed_addr_data_port_oe_o,
    output reg  [7:0]  high_address_port_o,
    output reg         addr_latch_o,
    output reg         rd_n_o,
    output reg         wr_n_o,
    // Machine cycle marker
    output reg         mc_tick_o
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_ADDR = 4'b0010;
    localparam [3:0] ST_STRB = 4'b0100;
    localparam [3:0] ST_TAIL = 4'b1000;

    reg  [7:0]  clock_and_stretch_control_q;
    reg  [1:0]  phase_q;
    reg  [3:0]  state_q;
    reg  [3:0]  state_d;
    reg  [5:0]  cnt_q;
    reg  [5:0]  total_q;
    reg  [4:0]  strobe_q;
    reg         wr_q;
    reg  [7:0]  wdat_q;
    wire [15:0] ptr0;
    wire [15:0] ptr1;
    wire        sel;
    wire [2:0]  stretch = clock_and_stretch_control_q[`SXDAP_STRETCH_MSB:`SXDAP_STRETCH_LSB]; // see RQ2

    // Strobe width in clocks for a given stretch setting.
    function [4:0] strobe_clks;
        input [2:0] s;
        begin
            if (s == 3'h0) strobe_clks = `SXDAP_STROBE_ZERO; // see RQ5
            else strobe_clks = {s, 2'h0}; // see RQ5
        end
    endfunction

    // Whole move length in clocks: stretch plus two machine cycles.
    function [5:0] move_clks;
        input [2:0] s;
        begin
            move_clks = {({1'b0, s} + `SXDAP_MIN_MC), 2'h0}; // see RQ3
        end
    endfunction

    // Register-bus read data for an address; shared by the read mux.
    function [7:0] reg_read;
        input [7:0] a;
        begin
            case (a)
                `SXDAP_ADDR_PTR0_LOW:  reg_read = ptr0[7:0];
                `SXDAP_ADDR_PTR0_HIGH: reg_read = ptr0[15:8];
                `SXDAP_ADDR_PTR1_LOW:  reg_read = ptr1[7:0];
                `SXDAP_ADDR_PTR1_HIGH: reg_read = ptr1[15:8];
                `SXDAP_ADDR_PTR_SEL:   reg_read = {7'h00, sel}; // see RQ11
                `SXDAP_ADDR_CLOCK_AND_STRETCH_CONTROL:     reg_read = clock_and_stretch_control_q;
                default:               reg_read = 8'h00;
            endcase
        end
    endfunction

    sxdap_ptr_bank u_ptr (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .wr_i       (sfr_wr_i),
        .addr_i     (sfr_addr_i),
        .wdata_i    (sfr_wdata_i),
        .inc_ptr_i  (inc_ptr_i),
        .inc_sel_i  (inc_sel_i),
        .load_ptr_i (load_ptr_i),
        .load_val_i (load_val_i),
        .ptr0_o     (ptr0),
        .ptr1_o     (ptr1),
        .sel_o      (sel)
    );

    // Clock control; the timer-speed bits are stored but unused here.
    always @(posedge clk_i) begin
        if (rst_i) begin
            clock_and_stretch_control_q <= `SXDAP_CLOCK_AND_STRETCH_CONTROL_RESET; // see RQ4
        end else if (sfr_wr_i && sfr_addr_i == `SXDAP_ADDR_CLOCK_AND_STRETCH_CONTROL) begin
            clock_and_stretch_control_q <= sfr_wdata_i; // see RQ7
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            sfr_rdata_o <= reg_read(sfr_addr_i);
        end
    end

    // Free-running machine cycle phase.
    always @(posedge clk_i) begin
        if (rst_i) begin
            phase_q   <= 2'h0;
            mc_tick_o <= 1'b0;
        end else begin
            phase_q   <= phase_q + 2'h1; // see RQ1
            mc_tick_o <= (phase_q == 2'h3);
        end
    end

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (xmove_req_i) state_d = ST_ADDR;
            ST_ADDR: if (cnt_q == {1'b0, `SXDAP_ADDR_CLKS} - 6'h01) state_d = ST_STRB;
            ST_STRB: if (cnt_q == {1'b0, `SXDAP_ADDR_CLKS} + {1'b0, strobe_q} - 6'h01)
                state_d = ST_TAIL;
            ST_TAIL: if (cnt_q == total_q - 6'h01) state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // The stretch is sampled at the start of each move so a write mid-move
    // cannot tear the strobe; the new value takes effect from the next move.
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q                   <= ST_IDLE;
            cnt_q                     <= 6'h00;
            total_q                   <= 6'h00;
            strobe_q                  <= 5'h00;
            wr_q                      <= 1'b0;
            wdat_q                    <= 8'h00;
            xmove_busy_o              <= 1'b0;
            xmove_done_o              <= 1'b0;
            xmove_rdata_o             <= 8'h00;
            muxed_addr_data_port_o    <= 8'h00;
            muxed_addr_data_port_oe_o <= 1'b0;
            high_address_port_o       <= 8'h00;
            addr_latch_o              <= 1'b0;
            rd_n_o                    <= 1'b1;
            wr_n_o                    <= 1'b1;
        end else begin
            state_q      <= state_d;
            xmove_done_o <= 1'b0;
            addr_latch_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    cnt_q <= 6'h00;
                    if (xmove_req_i) begin
                        total_q      <= move_clks(stretch); // see RQ6
                        strobe_q     <= strobe_clks(stretch);
                        wr_q         <= xmove_write_i;
                        wdat_q       <= xmove_wdata_i;
                        xmove_busy_o <= 1'b1;
                        addr_latch_o <= 1'b1;
                        muxed_addr_data_port_oe_o <= 1'b1;
                        // Pointer moves use the selected pointer; others send xmove_ri_addr_i.
                        if (xmove_use_ptr_i) begin // see RQ12
                            muxed_addr_data_port_o <= sel ? ptr1[7:0] : ptr0[7:0]; // see RQ8
                            high_address_port_o    <= sel ? ptr1[15:8] : ptr0[15:8]; // see RQ8
                        end else begin
                            muxed_addr_data_port_o <= xmove_ri_addr_i;
                        end
                    end
                end
                ST_ADDR: begin
                    cnt_q <= cnt_q + 6'h01;
                    if (state_d == ST_STRB) begin
                        if (wr_q) begin
                            muxed_addr_data_port_o <= wdat_q;
                            wr_n_o                 <= 1'b0;
                        end else begin
                            muxed_addr_data_port_oe_o <= 1'b0;
                            rd_n_o                    <= 1'b0;
                        end
                    end
                end
                ST_STRB: begin
                    cnt_q <= cnt_q + 6'h01;
                    if (state_d == ST_TAIL) begin
                        // Read data is taken at the strobe's trailing edge.
                        if (!wr_q) xmove_rdata_o <= muxed_addr_data_port_i; // see RQ15
                        rd_n_o <= 1'b1;
                        wr_n_o <= 1'b1;
                    end
                end
                ST_TAIL: begin
                    cnt_q <= cnt_q + 6'h01;
                    if (state_d == ST_IDLE) begin
                        xmove_busy_o              <= 1'b0;
                        xmove_done_o              <= 1'b1; // see RQ3
                        muxed_addr_data_port_oe_o <= 1'b0;
                    end
                end
                default: cnt_q <= 6'h00;
            endcase
        end
    end
endmodule // sxdap_top
`default_nettype wire

/* tb/stretched_xdata_access_dual_ptr_tb.sv */
// Self-checking bench for the stretched data move unit with dual pointers.
// Assumes the RAM model answers within any strobe width the stretch allows.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
    $display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module stretched_xdata_access_dual_ptr_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, req = 1'b0, mw = 1'b0;
    logic        ld = 1'b0, inc_p = 1'b0, inc_s = 1'b0, busy, done, oe, lat, rd_n, wr_n, tick;
    logic [7:0]  addr = 8'h00, wd = 8'h00, mwd = 8'h00, rdata, mrd, pin_o, hi, ram_o, q;
    logic [15:0] ld_val = 16'h0000;
    logic        up = 1'b1;
    logic [7:0]  ri = 8'h00;
    wire  [7:0]  pin_w = oe ? pin_o : ram_o;
    int          mismatches = 0, samples_checked = 0;
    always #50 clk_i = ~clk_i;
    sxdap_top i_sxdap_top (.clk_i(clk_i), .rst_i(rst_i), .sfr_wr_i(wr), .sfr_rd_i(rd),
        .sfr_addr_i(addr), .sfr_wdata_i(wd), .sfr_rdata_o(rdata), .inc_ptr_i(inc_p),
        .inc_sel_i(inc_s), .load_ptr_i(ld), .load_val_i(ld_val), .xmove_req_i(req),
        .xmove_write_i(mw), .xmove_use_ptr_i(up), .xmove_ri_addr_i(ri),
        .xmove_wdata_i(mwd), .xmove_busy_o(busy), .xmove_done_o(done), .xmove_rdata_o(mrd),
        .muxed_addr_data_port_i(pin_w), .muxed_addr_data_port_o(pin_o),
        .muxed_addr_data_port_oe_o(oe), .high_address_port_o(hi), .addr_latch_o(lat),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .mc_tick_o(tick));
    sxdap_xram_model i_sxdap_xram_model (.clk_i(clk_i), .ad_i(pin_w), .high_i(hi),
        .latch_i(lat), .rd_n_i(rd_n), .wr_n_i(wr_n), .ad_o(ram_o));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {wr, addr, wd} = {1'b1, a, d};
        @(negedge clk_i);
        wr = 1'b0;
    endtask
    task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_i);
        {rd, addr} = {1'b1, a};
        @(negedge clk_i);
        rd = 1'b0;
        `CHK(rdata, exp)
    endtask
    task automatic core_op(input logic l, input logic ip, input logic is, input logic [15:0] v);
        @(negedge clk_i);
        {ld, inc_p, inc_s, ld_val} = {l, ip, is, v};
        @(negedge clk_i);
        {ld, inc_p, inc_s} = 3'b000;
    endtask
    // Counts clocks from the take edge to the done pulse, bounded so a hang ends the run.
    task automatic move(input logic w, input logic [7:0] d, input logic [2:0] s);
        int n;
        @(negedge clk_i);
        {req, mw, mwd} = {1'b1, w, d};
        @(negedge clk_i);
        req = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 60) begin
            @(negedge clk_i);
            n++;
        end
        `CHK(n, 4 * (s + 2))
        if (n >= 60) report_and_stop();
        q = mrd;
    endtask
    task automatic t_reset();
        move(1'b1, 8'h11, 3'h1);
        reg_chk(8'h82, 8'h00);
        reg_chk(8'h85, 8'h00);
        reg_chk(8'h86, 8'h00);
        reg_chk(8'h8E, 8'h01);
    endtask
    task automatic t_regs();
        reg_wr(8'h83, 8'h12);
        reg_wr(8'h84, 8'h78);
        reg_wr(8'h85, 8'h56);
        reg_wr(8'h86, 8'hFF);
        reg_wr(8'h8E, 8'hF8);
        reg_chk(8'h83, 8'h12);
        reg_chk(8'h85, 8'h56);
        reg_chk(8'h86, 8'h01);
        reg_chk(8'h8E, 8'hF8);
        reg_chk(8'h90, 8'h00);
    endtask
    task automatic t_ptr();
        reg_wr(8'h86, 8'h00);
        core_op(1'b1, 1'b0, 1'b0, 16'h00FF);
        core_op(1'b0, 1'b1, 1'b0, 16'h0000);
        reg_chk(8'h83, 8'h01);
        reg_chk(8'h84, 8'h78);
        core_op(1'b0, 1'b0, 1'b1, 16'h0000);
        reg_chk(8'h86, 8'h01);
        core_op(1'b0, 1'b1, 1'b0, 16'h0000);
        reg_chk(8'h84, 8'h79);
        reg_chk(8'h82, 8'h00);
    endtask
    // Each stretch is rewritten between moves, so a stale setting shows as a wrong length.
    task automatic t_moves();
        for (int s = 0; s < 8; s++) begin
            reg_wr(8'h8E, 8'(s));
            move(1'b1, 8'hA0 + 8'(s), 3'(s));
            move(1'b0, 8'h00, 3'(s));
            `CHK(q, 8'hA0 + 8'(s))
        end
    endtask
    // A register-addressed move keeps the high port from the last pointer move.
    task automatic t_ri();
        up = 1'b0;
        ri = 8'h3C;
        move(1'b1, 8'h5A, 3'h7);
        move(1'b0, 8'h00, 3'h7);
        `CHK(q, 8'h5A)
        `CHK(hi, 8'h56)
        up = 1'b1;
        move(1'b0, 8'h00, 3'h7);
        `CHK(q, 8'hA7)
    endtask
    initial begin
        repeat (20) @(negedge clk_i);
        rst_i = 1'b0;
        t_reset();
        t_regs();
        t_ptr();
        t_moves();
        t_ri();
        report_and_stop();
    end
endmodule // stretched_xdata_access_dual_ptr_tb
`default_nettype wire

/* tb/sxdap_asserts.sv */
// Assertions for the stretched data move unit, bound to sxdap_top.
// Sees only top-level ports; the stretch in force is tracked from register writes.
`timescale 1ns/1ns
`default_nettype none
module sxdap_asserts (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // Register bus
    input wire logic       sfr_wr_i,
    input wire logic       sfr_rd_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    // Move and pins
    input wire logic       xmove_req_i,
    input wire logic       xmove_busy_o,
    input wire logic       xmove_done_o,
    input wire logic       muxed_addr_data_port_oe_o,
    input wire logic       addr_latch_o,
    input wire logic       rd_n_o,
    input wire logic       wr_n_o,
    input wire logic       mc_tick_o
);
    logic [2:0] stretch_q;
    logic [2:0] run_q;
    logic [5:0] len_q;
    logic [5:0] low_q;
    wire        idle_w = rd_n_o && wr_n_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // The stretch is latched at take, because a rewrite must only reach later moves.
    always @(posedge clk_i) begin
        if (rst_i) begin
            stretch_q <= 3'h1;
            run_q     <= 3'h1;
            len_q     <= 6'h00;
            low_q     <= 6'h00;
        end else begin
            if (sfr_wr_i && sfr_addr_i == 8'h8E) stretch_q <= sfr_wdata_i[2:0];
            if (xmove_req_i && !xmove_busy_o) run_q <= stretch_q;
            len_q <= (xmove_req_i && !xmove_busy_o) ? 6'h00 : len_q + {5'h00, xmove_busy_o};
            low_q <= idle_w ? 6'h00 : low_q + 6'h01;
        end
    end
    sequence take_s; xmove_req_i && !xmove_busy_o; endsequence
    sequence addr_s; xmove_busy_o && addr_latch_o && muxed_addr_data_port_oe_o; endsequence
    tick_period_a: assert property (mc_tick_o |=> !mc_tick_o [*3] ##1 mc_tick_o)
        else $error("machine cycle is not four clocks");
    move_start_a: assert property (take_s |=> addr_s)
        else $error("address phase missing after take");
    move_bound_a: assert property (take_s |-> ##[9:37] xmove_done_o)
        else $error("move did not finish within nine machine cycles");
    move_len_a: assert property (xmove_done_o |-> len_q == ({3'h0, run_q} + 6'h02) * 6'h04)
        else $error("move length differs from stretch plus two cycles");
    strobe_width_a: assert property ($rose(idle_w) |->
        low_q == ((run_q == 3'h0) ? 6'h02 : {1'b0, run_q, 2'b00}))
        else $error("strobe width differs from stretch");
    done_pulse_a: assert property (xmove_done_o |-> !xmove_busy_o ##1 !xmove_done_o)
        else $error("done is not a single cycle after busy");
    read_release_a: assert property (!rd_n_o |-> wr_n_o && !muxed_addr_data_port_oe_o)
        else $error("port driven during read strobe");
    sel_read_a: assert property (sfr_rd_i && sfr_addr_i == 8'h86 |=> sfr_rdata_o[7:1] == 7'h00)
        else $error("select register upper bits not zero");
    stretch_read_a: assert property (sfr_rd_i && !sfr_wr_i && sfr_addr_i == 8'h8E
        |=> sfr_rdata_o[2:0] == stretch_q)
        else $error("stretch readback wrong");
endmodule // sxdap_asserts
bind sxdap_top sxdap_asserts i_sxdap_asserts (.clk_i(clk_i), .rst_i(rst_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .xmove_req_i(xmove_req_i),
    .xmove_busy_o(xmove_busy_o), .xmove_done_o(xmove_done_o),
    .muxed_addr_data_port_oe_o(muxed_addr_data_port_oe_o), .addr_latch_o(addr_latch_o),
    .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .mc_tick_o(mc_tick_o));
`default_nettype wire

/* tb/sxdap_xram_model.sv */
// Behavioural external data RAM on the muxed address/data port.
// Assumes the address comes with the latch pulse and data moves while a strobe is low.
`timescale 1ns/1ns
`default_nettype none
module sxdap_xram_model (
    // Clock
    input  wire logic       clk_i,
    // Memory pins
    input  wire logic [7:0] ad_i,
    input  wire logic [7:0] high_i,
    input  wire logic       latch_i,
    input  wire logic       rd_n_i,
    input  wire logic       wr_n_i,
    output logic      [7:0] ad_o
);
    logic [7:0]  mem [0:65535];
    logic [15:0] addr_q;
    logic [7:0]  last_q = 8'h00;
    always @(posedge clk_i) begin
        if (latch_i) addr_q <= {high_i, ad_i};
        if (!wr_n_i) mem[addr_q] <= ad_i;
        last_q <= ad_o;
    end
    // A released bus flips every cycle so that a stale read can never pass.
    assign ad_o = !rd_n_i ? mem[addr_q] : ~last_q;
endmodule // sxdap_xram_model
`default_nettype wire
